// ==== logic/cubist_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module cubist_host (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output cubist_pkg::cub_port_type port,
  output cubist_pkg::cub_wrap_type wrap,
  input wire logic [23:0] test_data_out
);
  ////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [31:0] ctrl_reg;
  logic [15:0] instr_reg;
  logic [23:0] wdata_reg;
  logic [23:0] rdata_reg;
  logic [15:0] count_reg;
  logic [15:0] limit_reg;
  // Status flags
  logic rdValid_reg;
  logic busy_reg;
  logic doneSticky_reg;
  // Sequencer, entry counting and upload pending flag
  cubist_pkg::cub_state_type state_reg;
  logic [4:0] cnt_reg;
  logic [1:0] beat_reg;
  logic [15:0] beats_reg;
  logic wrFull_reg;
  // Write channel holding registers
  logic [7:0] awAddr_reg;
  logic [31:0] awData_reg;
  logic haveAw_reg;
  logic haveW_reg;
  // Decoded array select and strobes
  logic [2:0] sel;
  logic writeGo;
  logic wrWdata;
  logic rdRdata;
  logic beatEnd;

  // Decodes; read data clear keys off the accepted read address
  assign sel = ctrl_reg[cubist_pkg::CUB_CTRL_SEL_LO +: 3];
  assign writeGo = haveAw_reg && haveW_reg && !s_axi_bvalid;
  assign wrWdata = writeGo && awAddr_reg == cubist_pkg::CUB_WDATA_OFS;
  assign rdRdata = s_axi_arvalid && s_axi_arready && s_axi_araddr == cubist_pkg::CUB_RDATA_OFS;
  assign beatEnd = beat_reg == 2'(cubist_pkg::CUB_BEAT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Write address and data, taken in either order
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      haveAw_reg <= 1'b0;
      haveW_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      awData_reg <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      // Ready offered every other cycle until the beat is held
      s_axi_awready <= !haveAw_reg && !s_axi_awready;
      s_axi_wready <= !haveW_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW_reg <= 1'b1;
        awData_reg <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (writeGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_reg > cubist_pkg::CUB_WRAP_OFS || awAddr_reg[1:0] != 2'h0) ?
          2'h2 : 2'h0;
        haveAw_reg <= 1'b0;
        haveW_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register stores; strobes ignored, whole word writes only
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_reg <= 32'h00000000;
      instr_reg <= 16'h0000;
      wdata_reg <= 24'h000000;
      limit_reg <= 16'h0000;
      wrap <= '0;
    end else if (writeGo) begin
      // Unmapped or unaligned writes change nothing
      case (awAddr_reg)
        cubist_pkg::CUB_CTRL_OFS: ctrl_reg <= awData_reg;
        cubist_pkg::CUB_INSTR_OFS: instr_reg <= awData_reg[15:0];
        cubist_pkg::CUB_WDATA_OFS: wdata_reg <= awData_reg[23:0];
        cubist_pkg::CUB_COUNT_OFS: limit_reg <= awData_reg[15:0];
        cubist_pkg::CUB_WRAP_OFS: wrap <= awData_reg[4:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end else if (busy_reg) begin
      // Dropped once the sequencer has taken it
      ctrl_reg[cubist_pkg::CUB_CTRL_START] <= 1'b0; // Start is a one-shot
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      // Ready offered on alternate cycles while no answer is pending
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          cubist_pkg::CUB_CTRL_OFS: s_axi_rdata <= ctrl_reg;
          cubist_pkg::CUB_STAT_OFS: s_axi_rdata <= {28'h0, wrFull_reg, doneSticky_reg,
            rdValid_reg, busy_reg};
          cubist_pkg::CUB_INSTR_OFS: s_axi_rdata <= {16'h0, instr_reg};
          cubist_pkg::CUB_WDATA_OFS: s_axi_rdata <= {8'h0, wdata_reg};
          cubist_pkg::CUB_RDATA_OFS: s_axi_rdata <= {8'h0, rdata_reg};
          cubist_pkg::CUB_COUNT_OFS: s_axi_rdata <= {16'h0, count_reg};
          cubist_pkg::CUB_WRAP_OFS: s_axi_rdata <= {27'h0, wrap};
          // Unmapped reads answer with an error code
          default: begin
            s_axi_rdata <= cubist_pkg::CUB_SLVERR;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: hard reset, program at 0x6, run, return to 0x6
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= cubist_pkg::CUB_IDLE;
      cnt_reg <= 5'h00;
      busy_reg <= 1'b0;
    end else begin
      case (state_reg)
        cubist_pkg::CUB_IDLE: begin
          // Out-of-range select never leaves idle: no translation array path
          if (ctrl_reg[cubist_pkg::CUB_CTRL_START] && sel <= cubist_pkg::CUB_SEL_MAXARR) begin
            busy_reg <= 1'b1;
            cnt_reg <= 5'h00;
            state_reg <= ctrl_reg[cubist_pkg::CUB_CTRL_HRST] ?
              cubist_pkg::CUB_HRST : cubist_pkg::CUB_SETUP;
          end
        end
        cubist_pkg::CUB_HRST: begin
          // Device held in hard reset, which also wipes the caches
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'(cubist_pkg::CUB_HRST_CYCLES - 1)) begin
            cnt_reg <= 5'h00;
            state_reg <= cubist_pkg::CUB_SETUP;
          end
        end
        cubist_pkg::CUB_SETUP: begin
          cnt_reg <= cnt_reg + 5'h01; // Hold 0x6 while instruction settles
          if (cnt_reg == 5'(cubist_pkg::CUB_BEAT_CYCLES - 1)) begin
            cnt_reg <= 5'h00;
            state_reg <= cubist_pkg::CUB_RUN;
          end
        end
        cubist_pkg::CUB_RUN: begin
          // Saturates one past the read slot, so only the first word is taken
          if (cnt_reg != 5'(cubist_pkg::CUB_FIRST_READ_CYCLES + 1)) begin
            cnt_reg <= cnt_reg + 5'h01;
          end
          // End only on a beat boundary so no entry is left half written
          if (beatEnd && beats_reg + 16'h1 >= limit_reg) begin
            state_reg <= cubist_pkg::CUB_END;
          end
        end
        cubist_pkg::CUB_END: begin
          // Select is back at 0x6 before software may start again
          busy_reg <= 1'b0;
          state_reg <= cubist_pkg::CUB_IDLE;
        end
        default: state_reg <= cubist_pkg::CUB_IDLE;
      endcase
    end
  end

  // Beat and entry counters, address advances every fourth cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      beat_reg <= 2'h0;
      beats_reg <= 16'h0000;
      count_reg <= 16'h0000;
    end else if (state_reg == cubist_pkg::CUB_RUN) begin
      beat_reg <= beat_reg + 2'h1;
      if (beatEnd) begin
        beats_reg <= beats_reg + 16'h1;
        count_reg <= beats_reg + 16'h1;
      end
    end else begin
      // Cleared outside a run so each run counts from zero
      beat_reg <= 2'h0;
      beats_reg <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data staging: one word per run, software paces via full flag
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wrFull_reg <= 1'b0;
      rdata_reg <= 24'h000000;
      rdValid_reg <= 1'b0;
      doneSticky_reg <= 1'b0;
    end else begin
      // Pending until the word has gone out on the link
      if (wrWdata) begin
        wrFull_reg <= 1'b1;
      end else if (state_reg == cubist_pkg::CUB_RUN) begin
        wrFull_reg <= 1'b0;
      end
      // Download sample once first read latency has passed; set wins over clear
      if (state_reg == cubist_pkg::CUB_RUN && !ctrl_reg[cubist_pkg::CUB_CTRL_DIR] &&
          cnt_reg == 5'(cubist_pkg::CUB_FIRST_READ_CYCLES)) begin
        rdata_reg <= test_data_out;
        rdValid_reg <= 1'b1;
      end else if (rdRdata) begin
        rdValid_reg <= 1'b0;
      end
      // Sticky completion view held until the next run starts
      if (state_reg == cubist_pkg::CUB_SETUP) begin
        doneSticky_reg <= 1'b0;
      end else if (test_data_out[cubist_pkg::CUB_DONE_BIT]) begin
        doneSticky_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device test port drive
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      port.testConfigSelect <= cubist_pkg::CUB_SEL_RESET;
      port.testDataIn <= 24'h000000;
      port.wrapperInputMuxSelect <= 1'b0;
      port.safeStateControl <= 1'b0;
      port.hardResetN <= 1'b1;
    end else begin
      // Hard reset follows the sequencer state one cycle later
      port.hardResetN <= state_reg != cubist_pkg::CUB_HRST;
      case (state_reg)
        cubist_pkg::CUB_SETUP: begin
          port.testConfigSelect <= cubist_pkg::CUB_SEL_RESET;
          // Execute-on-completion only allowed on the last array
          port.testDataIn <= {8'h00,
            (ctrl_reg[cubist_pkg::CUB_CTRL_LAST] && ctrl_reg[cubist_pkg::CUB_CTRL_DIR]) ?
            cubist_pkg::CUB_ENG_EXEC : cubist_pkg::CUB_ENG_NORMAL,
            cubist_pkg::CUB_TGT_RAM, instr_reg[7:4],
            ctrl_reg[cubist_pkg::CUB_CTRL_DIR] ?
            cubist_pkg::CUB_PAT_WSOLID : cubist_pkg::CUB_PAT_RSOLID};
        end
        cubist_pkg::CUB_RUN: begin
          port.testConfigSelect <= sel;
          // Upload word presented on every cycle of the entry
          port.testDataIn <= wdata_reg;
          // Toggle wrapper controls throughout every run, upload or download
          port.wrapperInputMuxSelect <= ~port.wrapperInputMuxSelect;
          port.safeStateControl <= ~port.safeStateControl;
        end
        default: begin
          port.testConfigSelect <= cubist_pkg::CUB_SEL_RESET;
          port.wrapperInputMuxSelect <= 1'b0;
          port.safeStateControl <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/cubist_pkg.sv ====
package cubist_pkg;
  // Register byte offsets of the controller
  localparam logic [7:0] CUB_CTRL_OFS = 8'h00;
  localparam logic [7:0] CUB_STAT_OFS = 8'h04;
  localparam logic [7:0] CUB_INSTR_OFS = 8'h08;
  localparam logic [7:0] CUB_WDATA_OFS = 8'h0C;
  localparam logic [7:0] CUB_RDATA_OFS = 8'h10;
  localparam logic [7:0] CUB_COUNT_OFS = 8'h14;
  localparam logic [7:0] CUB_WRAP_OFS = 8'h18;
  // Control bit positions
  localparam int CUB_CTRL_START = 0;
  localparam int CUB_CTRL_DIR = 1;
  localparam int CUB_CTRL_LAST = 2;
  localparam int CUB_CTRL_HRST = 3;
  localparam int CUB_CTRL_SEL_LO = 4;
  // Test configuration select codes
  localparam logic [2:0] CUB_SEL_RESET = 3'h6;
  localparam logic [2:0] CUB_SEL_ICACHE = 3'h0;
  localparam logic [2:0] CUB_SEL_DCACHE = 3'h1;
  localparam logic [2:0] CUB_SEL_MAXARR = 3'h5;
  // Instruction fields
  localparam logic [3:0] CUB_ENG_NORMAL = 4'h0;
  localparam logic [3:0] CUB_ENG_EXEC = 4'hF;
  localparam logic [3:0] CUB_TGT_RAM = 4'h1;
  localparam logic [3:0] CUB_PAT_WSOLID = 4'h0;
  localparam logic [3:0] CUB_PAT_RSOLID = 4'h1;
  localparam logic [15:0] CUB_RELOAD_CTRL = 16'h01C1;
  // Timing, done flag bit and read error word
  localparam int CUB_BEAT_CYCLES = 4;
  localparam int CUB_FIRST_READ_CYCLES = 11;
  localparam int CUB_HRST_CYCLES = 16;
  localparam int CUB_DONE_BIT = 9;
  localparam logic [31:0] CUB_SLVERR = 32'hDEADBEEF;
  // Wrapper pin group driven during upload
  typedef struct packed {
    logic fastInterruptN;
    logic interruptRequestN;
    logic interruptSyncSelect;
    logic coprocBounceInput;
    logic debugEnableInput;
  } cub_wrap_type;
  // Device test port drive
  typedef struct packed {
    logic [2:0] testConfigSelect;
    logic [23:0] testDataIn;
    logic wrapperInputMuxSelect;
    logic safeStateControl;
    logic hardResetN;
  } cub_port_type;
  typedef enum logic [4:0] {
    CUB_IDLE = 5'b00001,
    CUB_HRST = 5'b00010,
    CUB_SETUP = 5'b00100,
    CUB_RUN = 5'b01000,
    CUB_END = 5'b10000
  } cub_state_type;
endpackage

// ==== verif/cub_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module cub_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire cubist_pkg::cub_port_type port,
  input wire cubist_pkg::cub_wrap_type wrap
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [2:0] sel;
  logic [9:0] runCnt;
  assign sel = port.testConfigSelect;
  // Cycles away from idle, so a run that stops mid-entry shows up
  always_ff @(posedge sys_clk) begin
    if (!resetn || sel == 3'h6) runCnt <= 10'h000;
    else runCnt <= runCnt + 10'h001;
  end
  ////////////////////////////////////////
  // Test port sequencing
  property p_selRange; sel == 3'h6 || sel <= 3'h5; endproperty
  a_selRange: assert property (p_selRange) else $error("select out of range");
  property p_hrstSel; !port.hardResetN |-> sel == 3'h6; endproperty
  a_hrstSel: assert property (p_hrstSel) else $error("hard reset outside idle");
  property p_hrstLen; $fell(port.hardResetN) |=> !port.hardResetN [*8]; endproperty
  a_hrstLen: assert property (p_hrstLen) else $error("hard reset too short");
  property p_toggle;
    sel != 3'h6 && $past(sel) != 3'h6 |->
      port.wrapperInputMuxSelect != $past(port.wrapperInputMuxSelect) &&
      port.safeStateControl != $past(port.safeStateControl);
  endproperty
  a_toggle: assert property (p_toggle) else $error("wrapper controls not toggling");
  // Instruction word left on the bus just before a run starts
  property p_setup;
    sel != 3'h6 && $past(sel) == 3'h6 |-> $past(port.testDataIn[11:8]) == 4'h1 &&
      $past(port.testDataIn[3:0]) inside {4'h0, 4'h1};
  endproperty
  a_setup: assert property (p_setup) else $error("bad run instruction");
  property p_runEnds; sel != 3'h6 && $past(sel) == 3'h6 |-> ##[4:600] sel == 3'h6; endproperty
  a_runEnds: assert property (p_runEnds) else $error("run never ended");
  property p_runBeat; sel == 3'h6 && $past(sel) != 3'h6 |-> runCnt[1:0] == 2'h0; endproperty
  a_runBeat: assert property (p_runBeat) else $error("run ended mid entry");
  property p_wrapHold; sel != 3'h6 |-> $stable(wrap); endproperty
  a_wrapHold: assert property (p_wrapHold) else $error("wrapper moved in run");
endmodule
bind cubist_host cub_asserts i_cub_asserts (.sys_clk, .resetn, .port, .wrap);
`default_nettype wire

// ==== verif/cub_device_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cub_device_model (
  input wire logic sys_clk,
  input wire cubist_pkg::cub_port_type port,
  output logic [23:0] test_data_out
);
  logic [23:0] arrayWord [0:5];
  logic [3:0] patReg;
  logic [4:0] runCnt;
  logic [2:0] sel;
  assign sel = port.testConfigSelect;
  ////////////////////////////////////////
  // Run cycle count; pattern captured while idle
  always_ff @(posedge sys_clk) begin
    if (sel == 3'h6) begin
      runCnt <= 5'h00;
      patReg <= port.testDataIn[3:0];
    end else if (runCnt != 5'h1F) begin
      runCnt <= runCnt + 5'h01;
    end
  end
  // Hard reset wipes, upload stores, download reads destructively
  always_ff @(posedge sys_clk) begin
    if (!port.hardResetN) begin
      for (int i = 0; i < 6; i++) arrayWord[i] <= 24'h000000;
    end else if (sel <= 3'h5 && runCnt == 5'h01) begin
      if (patReg == 4'h0) arrayWord[sel] <= port.testDataIn;
    end else if (sel <= 3'h5 && runCnt == 5'h0B) begin
      arrayWord[sel] <= 24'h000000;
    end
  end
  // Word only in its read slot; elsewhere in a run a moving inverse so late samples never match
  always_comb begin
    if (sel <= 3'h5 && (runCnt == 5'h0A || runCnt == 5'h0B)) begin
      test_data_out = arrayWord[sel];
    end else if (sel == 3'h6) begin
      test_data_out = 24'h000000; // Engine held in reset: completion and fail flags clear
    end else begin
      test_data_out = ~{runCnt, runCnt, runCnt, runCnt, runCnt[3:0]};
    end
  end
endmodule
`default_nettype wire

// ==== verif/test_cache_upload_download_bist.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_cache_upload_download_bist;
  logic sys_clk = 1'b0, resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  cubist_pkg::cub_port_type port;
  cubist_pkg::cub_wrap_type wrap;
  logic [23:0] test_data_out, setupWord, prevData;
  logic [2:0] prevSel;
  logic leftIdle;
  int n_mismatch = 0, n_tests = 0, hrstLow = 0, i;
  logic [2:0] dlSel [7] = '{3'h2, 3'h3, 3'h2, 3'h0, 3'h1, 3'h4, 3'h5};
  logic [23:0] dlExp [7] = '{24'hA5C3F0, 24'h5A3C0F, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
  cubist_host i_cubist_host (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port, .wrap, .test_data_out);
  cub_device_model i_cub_device_model (.sys_clk, .port, .test_data_out);
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  // Pin monitor: last idle word before a run, hard reset length, any run
  always @(posedge sys_clk) begin
    prevSel <= port.testConfigSelect;
    prevData <= port.testDataIn;
    if (port.testConfigSelect != 3'h6 && prevSel == 3'h6) setupWord <= prevData;
    if (!port.hardResetN) hrstLow <= hrstLow + 1;
    if (port.testConfigSelect != 3'h6) leftIdle <= 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo();
    chk("handshake", 32'h1, 32'h0);
    wrap_up();
  endtask
  // Bus tasks; each valid is dropped only on the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge sys_clk); // Spare edge so no handshake signal is set twice in one step
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 300; k++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (k == 300) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 300; k++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (k == 300) tmo();
  endtask
  // One transfer: entry limit, start, then poll busy
  task automatic run(input logic [31:0] ctrl, input logic [31:0] cnt);
    logic [31:0] d;
    logic [1:0] r;
    int k;
    wr(cubist_pkg::CUB_COUNT_OFS, cnt, r);
    @(negedge sys_clk);
    hrstLow = 0;
    leftIdle = 1'b0;
    @(posedge sys_clk);
    wr(cubist_pkg::CUB_CTRL_OFS, ctrl | 32'h1, r);
    for (k = 0; k < 300; k++) begin
      rd(cubist_pkg::CUB_STAT_OFS, d, r);
      if (d[0] === 1'b0) break;
    end
    if (k == 300) tmo();
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk("select", 32'h6, 32'(port.testConfigSelect));
    chk("hard reset", 32'h1, 32'(port.hardResetN));
    rd(cubist_pkg::CUB_STAT_OFS, d, r);
    chk("status", 32'h0, d);
    rd(8'h1C, d, r);
    chk("read resp", 32'h2, 32'(r));
    wr(8'h20, 32'h1, r);
    chk("write resp", 32'h2, 32'(r));
    $display("reset and map test done");
    // Last-array upload with hard reset, then a plain one
    wr(cubist_pkg::CUB_WRAP_OFS, 32'h1E, r);
    wr(cubist_pkg::CUB_WDATA_OFS, 32'hA5C3F0, r);
    rd(cubist_pkg::CUB_STAT_OFS, d, r);
    chk("pending status", 32'h8, d);
    run(32'h2E, 32'h0);
    chk("wrapper", 32'h1E, 32'(wrap));
    chk("hard reset cycles", cubist_pkg::CUB_HRST_CYCLES, hrstLow);
    chk("engine field", 32'hF, 32'(setupWord[15:12]));
    chk("upload pattern", 32'h0, 32'(setupWord[3:0]));
    rd(cubist_pkg::CUB_STAT_OFS, d, r);
    chk("sticky status", 32'h4, d);
    wr(cubist_pkg::CUB_WDATA_OFS, 32'h5A3C0F, r);
    run(32'h32, 32'h0);
    chk("engine field", 32'h0, 32'(setupWord[15:12]));
    chk("hard reset cycles", 32'h0, hrstLow);
    $display("upload test done");
    // Downloads of every array; a second read of one shows it was wiped
    wr(cubist_pkg::CUB_INSTR_OFS, 32'hC0, r);
    for (i = 0; i < 7; i++) begin
      run({25'h0, dlSel[i], 4'h0}, 32'h3);
      chk("download instr", 32'h011, 32'({setupWord[15:8], setupWord[3:0]}));
      chk("reload instr", 32'(cubist_pkg::CUB_RELOAD_CTRL), 32'(setupWord[15:0]));
      rd(cubist_pkg::CUB_STAT_OFS, d, r);
      chk("data valid", 32'h1, 32'(d[1]));
      rd(cubist_pkg::CUB_RDATA_OFS, d, r);
      chk("download word", 32'(dlExp[i]), 32'(d[23:0]));
      rd(cubist_pkg::CUB_STAT_OFS, d, r);
      chk("valid cleared", 32'h0, 32'(d[1]));
    end
    run(32'h70, 32'h0);
    chk("left idle", 32'h0, 32'(leftIdle));
    rd(cubist_pkg::CUB_COUNT_OFS, d, r);
    chk("entries done", 32'h3, d);
    $display("download test done");
    wrap_up();
  end
endmodule
`default_nettype wire
